// *** cabo_alu.sv ***
// Combinational decode and arithmetic for one instruction word.
// Assumes the caller supplies the addressed file register's current value.
`timescale 1ns/10ps
module cabo_alu
  import cabo_pkg::*;
(
  // Operands
  input  wire logic [13:0] instr,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  fileVal,
  // Results
  output logic [7:0]       result,
  output logic             writeAcc,
  output logic             writeFile,
  output logic             updArith,
  output logic             updZero,
  output logic             carryOut,
  output logic             digitCarryOut,
  output logic             zeroOut,
  output logic             skipNext,
  output logic             known
);

  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] opnd;
  logic [2:0] bitPos;
  logic       litForm;
  logic       destFile;

  always_comb begin
    litForm  = instr[OPC_HI:OPC_HI-1] == 2'h3;
    opnd     = litForm ? instr[7:0] : fileVal;
    bitPos   = instr[BPOS_HI:BPOS_LO];
    destFile = instr[DEST_POS];
    sum9     = {1'b0, acc} + {1'b0, opnd};
    sum5     = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
    result        = 8'h00;
    writeAcc      = 1'b0;
    writeFile     = 1'b0;
    updArith      = 1'b0;
    updZero       = 1'b0;
    skipNext      = 1'b0;
    known         = 1'b1;
    carryOut      = sum9[8];
    digitCarryOut = sum5[4];
    if (instr[OPC_HI:LIT_HI] == OPC_ADD_LIT) begin
      result   = sum9[7:0];
      writeAcc = 1'b1;
      updArith = 1'b1;
    end else if (instr[OPC_HI:OPC_LO] == OPC_AND_LIT) begin
      result   = acc & opnd;
      writeAcc = 1'b1;
      updZero  = 1'b1;
    end else if (instr[OPC_HI:OPC_LO] == OPC_ADD_ACC_FILE) begin
      result    = sum9[7:0];
      writeAcc  = !destFile;
      writeFile = destFile;
      updArith  = 1'b1;
    end else if (instr[OPC_HI:OPC_LO] == OPC_AND_ACC_FILE) begin
      result    = acc & opnd;
      writeAcc  = !destFile;
      writeFile = destFile;
      updZero   = 1'b1;
    end else if (instr[OPC_HI:BOP_LO] == BOP_CLEAR) begin
      result    = fileVal & ~(8'h01 << bitPos);
      writeFile = 1'b1;
    end else if (instr[OPC_HI:BOP_LO] == BOP_SET) begin
      result    = fileVal | (8'h01 << bitPos);
      writeFile = 1'b1;
    end else if (instr[OPC_HI:BOP_LO] == BOP_SKIP_ZERO) begin
      skipNext = !fileVal[bitPos];
    end else if (instr[OPC_HI:BOP_LO] == BOP_SKIP_ONE) begin
      skipNext = fileVal[bitPos];
    end else begin
      known = 1'b0;
    end
    zeroOut = result == 8'h00;
  end

endmodule

// *** cabo_exec_top.sv ***
// Execution block for add, AND, bit set/clear and bit-test-and-skip,
// reached over AXI4-Lite. Assumes a single 25 MHz clock and that software
// feeds one instruction at a time by writing the instruction register.
`timescale 1ns/10ps

module cabo_exec_top
  import cabo_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Write address channel
  input  wire logic        awvalid,
  input  wire logic [11:0] awaddr,
  output logic             awready,
  // Write data channel
  input  wire logic        wvalid,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             wready,
  // Write response channel
  output logic             bvalid,
  output logic [1:0]       bresp,
  input  wire logic        bready,
  // Read address channel
  input  wire logic        arvalid,
  input  wire logic [11:0] araddr,
  output logic             arready,
  // Read data channel
  output logic             rvalid,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        rready
);

  typedef struct packed {
    cabo_state_t      state;
    logic             awHeld;
    logic             wHeld;
    logic [11:0]      awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             awReady;
    logic             wReady;
    logic             bValid;
    logic [1:0]       bResp;
    logic             arReady;
    logic             rValid;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic [13:0]      instr;
    logic [7:0]       acc;
    logic             carryFlag;
    logic             digitCarryFlag;
    logic             zeroFlag;
    logic             skipPending;
    logic             illegalSeen;
    logic [15:0]      cycleCount;
    logic [127:0][7:0] fileMem;
  } cabo_regs_t;

  cabo_regs_t st;
  cabo_regs_t next_st;

  logic [7:0] aluResult;
  logic       aluWriteAcc;
  logic       aluWriteFile;
  logic       aluUpdArith;
  logic       aluUpdZero;
  logic       aluCarry;
  logic       aluDigit;
  logic       aluZero;
  logic       aluSkip;
  logic       aluKnown;
  logic [6:0] fileAdr;

  assign fileAdr = st.instr[FADR_HI:0];

  cabo_alu u_alu (
    .instr         (st.instr),
    .acc           (st.acc),
    .fileVal       (st.fileMem[fileAdr]),
    .result        (aluResult),
    .writeAcc      (aluWriteAcc),
    .writeFile     (aluWriteFile),
    .updArith      (aluUpdArith),
    .updZero       (aluUpdZero),
    .carryOut      (aluCarry),
    .digitCarryOut (aluDigit),
    .zeroOut       (aluZero),
    .skipNext      (aluSkip),
    .known         (aluKnown)
  );

  function automatic logic [31:0] read_word(input cabo_regs_t s,
                                            input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[11:2] == OFF_INSTR[11:2]) begin
      v[13:0] = s.instr;
    end else if (a[11:2] == OFF_ACC[11:2]) begin
      v[7:0] = s.acc;
    end else if (a[11:2] == OFF_STATUS[11:2]) begin
      v[ST_CARRY]   = s.carryFlag;
      v[ST_DIGIT]   = s.digitCarryFlag;
      v[ST_ZERO]    = s.zeroFlag;
      v[ST_SKIP]    = s.skipPending;
      v[ST_ILLEGAL] = s.illegalSeen;
    end else if (a >= OFF_FILE && a <= OFF_FILE_END + 12'h003) begin
      v[7:0] = s.fileMem[a[8:2]];
    end else if (a[11:2] == OFF_CYCLES[11:2]) begin
      v[15:0] = s.cycleCount;
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a[11:2] == OFF_INSTR[11:2] || a[11:2] == OFF_ACC[11:2] ||
           a[11:2] == OFF_STATUS[11:2] || a[11:2] == OFF_CYCLES[11:2] ||
           (a >= OFF_FILE && a <= OFF_FILE_END + 12'h003);
  endfunction

  always_comb begin
    next_st = st;
    // Address and data are captured independently, in either order
    if (awvalid && st.awReady) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && st.wReady) begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    case (st.state)
      CABO_IDLE: begin
        if (st.awHeld && st.wHeld) begin
          next_st.state  = CABO_RESP;
          next_st.bValid = 1'b1;
          next_st.bResp  = RESP_OKAY;
          if (st.awAddr[11:2] == OFF_INSTR[11:2]) begin
            // Execution takes one more cycle before the response
            if (st.wStrb[0]) next_st.instr[7:0] = st.wData[7:0];
            if (st.wStrb[1]) next_st.instr[13:8] = st.wData[13:8];
            next_st.state  = CABO_EXEC;
            next_st.bValid = 1'b0;
          end else if (st.awAddr[11:2] == OFF_ACC[11:2]) begin
            if (st.wStrb[0]) next_st.acc = st.wData[7:0];
          end else if (st.awAddr[11:2] == OFF_STATUS[11:2]) begin
            if (st.wStrb[0]) begin
              next_st.carryFlag      = st.wData[ST_CARRY];
              next_st.digitCarryFlag = st.wData[ST_DIGIT];
              next_st.zeroFlag       = st.wData[ST_ZERO];
            end
          end else if (st.awAddr >= OFF_FILE &&
                       st.awAddr <= OFF_FILE_END + 12'h003) begin
            if (st.wStrb[0]) next_st.fileMem[st.awAddr[8:2]] = st.wData[7:0];
          end else if (!mapped(st.awAddr)) begin
            next_st.bResp = RESP_DECERR;
          end
        end
      end
      CABO_EXEC: begin
        next_st.state      = CABO_RESP;
        next_st.bValid     = 1'b1;
        next_st.cycleCount = st.cycleCount + 16'h0001;
        if (st.skipPending) begin
          // Discarded word runs as a no_operation_cycle
          next_st.skipPending = 1'b0;
        end else begin
          next_st.illegalSeen = st.illegalSeen | !aluKnown;
          next_st.skipPending = aluSkip;
          if (aluWriteAcc) next_st.acc = aluResult;
          if (aluWriteFile) next_st.fileMem[fileAdr] = aluResult;
          if (aluUpdArith) begin
            next_st.carryFlag      = aluCarry;
            next_st.digitCarryFlag = aluDigit;
          end
          if (aluUpdArith || aluUpdZero) begin
            next_st.zeroFlag = aluZero;
          end
        end
      end
      CABO_RESP: begin
        if (bready) begin
          next_st.bValid = 1'b0;
          next_st.awHeld = 1'b0;
          next_st.wHeld  = 1'b0;
          next_st.state  = CABO_IDLE;
        end
      end
      default: next_st.state = CABO_IDLE;
    endcase
    next_st.awReady = !next_st.awHeld;
    next_st.wReady  = !next_st.wHeld;
    // Reads are answered from the register image of the current cycle
    if (arvalid && st.arReady) begin
      next_st.rValid = 1'b1;
      next_st.rData  = read_word(st, araddr);
      next_st.rResp  = mapped(araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (st.rValid && rready) begin
      next_st.rValid = 1'b0;
    end
    next_st.arReady = !next_st.rValid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st            <= '0;
      st.state      <= CABO_IDLE;
      st.instr      <= RST_INSTR;
      st.acc        <= RST_ACC;
      st.cycleCount <= RST_CYCLES;
    end else begin
      st <= next_st;
    end
  end

  assign awready = st.awReady;
  assign wready  = st.wReady;
  assign bvalid  = st.bValid;
  assign bresp   = st.bResp;
  assign arready = st.arReady;
  assign rvalid  = st.rValid;
  assign rdata   = st.rData;
  assign rresp   = st.rResp;

  // Checks: an instruction commits on the edge that leaves CABO_EXEC
  logic execLive;
  assign execLive = st.state == CABO_EXEC && !st.skipPending;

  a_add_literal_sum: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:LIT_HI] == OPC_ADD_LIT |=>
      st.acc == 8'($past(st.acc) + $past(st.instr[7:0])))
    else $error("add literal result wrong");

  a_add_file_carry: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:OPC_LO] == OPC_ADD_ACC_FILE |=>
      st.carryFlag == ($past({1'b0, st.acc}) +
                       $past({1'b0, st.fileMem[fileAdr]}) > 9'h0ff))
    else $error("add file carry wrong");

  a_dest_file_keep: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:OPC_LO] == OPC_ADD_ACC_FILE &&
    st.instr[DEST_POS] |=> st.acc == $past(st.acc) && st.bValid)
    else $error("file destination touched accumulator");

  a_and_lit_flags: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:OPC_LO] == OPC_AND_LIT |=>
      $stable(st.carryFlag) && $stable(st.digitCarryFlag) &&
      st.zeroFlag == (st.acc == 8'h00))
    else $error("and literal flags wrong");

  a_and_file_acc: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:OPC_LO] == OPC_AND_ACC_FILE &&
    !st.instr[DEST_POS] |=>
      st.acc == ($past(st.acc) & $past(st.fileMem[fileAdr])))
    else $error("and file result wrong");

  a_bit_clear_low: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:BOP_LO] == BOP_CLEAR |=>
      !st.fileMem[fileAdr][st.instr[BPOS_HI:BPOS_LO]] &&
      $stable(st.zeroFlag) && $stable(st.carryFlag))
    else $error("bit clear failed");

  a_bit_set_high: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:BOP_LO] == BOP_SET |=>
      st.fileMem[fileAdr][st.instr[BPOS_HI:BPOS_LO]] &&
      $stable(st.zeroFlag) && $stable(st.digitCarryFlag))
    else $error("bit set failed");

  a_skip_zero_arm: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:BOP_LO] == BOP_SKIP_ZERO |=>
      st.skipPending == !$past(st.fileMem[fileAdr][st.instr[BPOS_HI:BPOS_LO]]))
    else $error("skip if zero decision wrong");

  a_skip_one_arm: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:BOP_LO] == BOP_SKIP_ONE |=>
      st.skipPending == $past(st.fileMem[fileAdr][st.instr[BPOS_HI:BPOS_LO]]))
    else $error("skip if one decision wrong");

  a_skip_no_effect: assert property (@(posedge clk) disable iff (rst)
    st.state == CABO_EXEC && (st.skipPending ||
      st.instr[OPC_HI:BOP_LO] == BOP_SKIP_ZERO ||
      st.instr[OPC_HI:BOP_LO] == BOP_SKIP_ONE) |=>
      $stable(st.fileMem) && $stable(st.acc) && $stable(st.zeroFlag) &&
      $stable(st.carryFlag) && $stable(st.digitCarryFlag))
    else $error("skip path changed state");

  a_zero_flag_add: assert property (@(posedge clk) disable iff (rst)
    execLive && st.instr[OPC_HI:LIT_HI] == OPC_ADD_LIT |=>
      st.zeroFlag == (st.acc == 8'h00) &&
      st.digitCarryFlag == ($past({1'b0, st.acc[3:0]}) +
                            $past({1'b0, st.instr[3:0]}) > 5'h0f))
    else $error("add literal zero or digit flag wrong");

endmodule

// *** cabo_pkg.sv ***
// Constants, field layout and state encoding for the bit and arithmetic
// execution block. Assumes a 14-bit instruction word and AXI4-Lite access.
package cabo_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_INSTR  = 12'h000;
  localparam logic [11:0] OFF_ACC    = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_CYCLES = 12'h00c;
  localparam logic [11:0] OFF_FILE   = 12'h200;
  localparam logic [11:0] OFF_FILE_END = 12'h3fc;

  // Status register bit positions
  localparam int ST_CARRY   = 0;
  localparam int ST_DIGIT   = 1;
  localparam int ST_ZERO    = 2;
  localparam int ST_SKIP    = 3;
  localparam int ST_ILLEGAL = 4;

  // Instruction word fields
  localparam int OPC_HI   = 13;
  localparam int OPC_LO   = 8;
  localparam int BOP_LO   = 10;
  localparam int LIT_HI   = 9;
  localparam int DEST_POS = 7;
  localparam int FADR_HI  = 6;
  localparam int BPOS_HI  = 9;
  localparam int BPOS_LO  = 7;

  // Opcodes
  localparam logic [5:0] OPC_ADD_ACC_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_ACC_FILE = 6'h05;
  localparam logic [5:0] OPC_AND_LIT      = 6'h39;
  localparam logic [4:0] OPC_ADD_LIT      = 5'h1f;
  localparam logic [3:0] BOP_CLEAR        = 4'h4;
  localparam logic [3:0] BOP_SET          = 4'h5;
  localparam logic [3:0] BOP_SKIP_ZERO    = 4'h6;
  localparam logic [3:0] BOP_SKIP_ONE     = 4'h7;

  // Reset values
  localparam logic [13:0] RST_INSTR  = 14'h0000;
  localparam logic [7:0]  RST_ACC    = 8'h00;
  localparam logic [15:0] RST_CYCLES = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    CABO_IDLE = 2'h0,
    CABO_EXEC = 2'h1,
    CABO_RESP = 2'h3
  } cabo_state_t;

endpackage

// *** testbench.sv ***
// Self-checking bench for the add, AND, bit set/clear and skip block.
// Assumes the block is reached only through its AXI4-Lite slave ports.
`timescale 1ns/10ps
module testbench
  import cabo_pkg::*;
;
  typedef struct packed {
    logic [13:0] instr;
    logic [6:0]  fIdx;
    logic [7:0]  accIn;
    logic [7:0]  fIn;
    logic [2:0]  stIn;
    logic [7:0]  accExp;
    logic [7:0]  fExp;
    logic [2:0]  stExp;
  } cabo_row_t;

  logic        clk;
  logic        rst;
  logic        awvalid;
  logic [11:0] awaddr;
  logic        awready;
  logic        wvalid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wready;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        bready;
  logic        arvalid;
  logic [11:0] araddr;
  logic        arready;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rready;
  int          miscompares;
  int          nCompared;
  cabo_row_t   rows [12];
  logic [31:0] skipRows [4];

  cabo_exec_top i_cabo_exec_top (
    .clk(clk), .rst(rst),
    .awvalid(awvalid), .awaddr(awaddr), .awready(awready),
    .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .wready(wready),
    .bvalid(bvalid), .bresp(bresp), .bready(bready),
    .arvalid(arvalid), .araddr(araddr), .arready(arready),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    if (miscompares == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  // Both address and data are offered together; each drops once taken.
  // No wait of its own: a missing answer is left to the watchdog.
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
    r = 2'h1;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    d = 32'hxxxxxxxx;
    r = 2'h1;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, 4'hf, r);
    check("write response", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rdChk(input string name, input logic [11:0] a,
                       input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    check(name, d, exp);
    check("read response", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic exec(input logic [13:0] instr);
    wr(OFF_INSTR, {18'h0, instr});
  endtask

  function automatic logic [11:0] fileAdr(input logic [6:0] f);
    return OFF_FILE + {3'h0, f, 2'h0};
  endfunction

  initial begin
    #(40 * 20000);
    miscompares++;
    test_done();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] c0;
    logic [1:0]  r;
    logic        skip;
    miscompares = 0;
    nCompared = 0;
    rst <= 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    awaddr <= 12'h000;
    araddr <= 12'h000;
    wdata <= 32'h0;
    wstrb <= 4'h0;
    // Rows: instr, file index, acc in, file in, flags in, expected values
    rows[0]  = '{14'h3e78, 7'h20, 8'h88, 8'h5a, 3'h0, 8'h00, 8'h5a, 3'h7};
    rows[1]  = '{14'h3f01, 7'h20, 8'h0e, 8'h5a, 3'h7, 8'h0f, 8'h5a, 3'h0};
    rows[2]  = '{14'h0705, 7'h05, 8'h0f, 8'h01, 3'h0, 8'h10, 8'h01, 3'h2};
    rows[3]  = '{14'h07ff, 7'h7f, 8'hf0, 8'h20, 3'h0, 8'hf0, 8'h10, 3'h1};
    rows[4]  = '{14'h390f, 7'h20, 8'hf0, 8'h33, 3'h3, 8'h00, 8'h33, 3'h7};
    rows[5]  = '{14'h39a5, 7'h20, 8'hff, 8'h33, 3'h7, 8'ha5, 8'h33, 3'h3};
    rows[6]  = '{14'h0503, 7'h03, 8'h3c, 8'h0f, 3'h0, 8'h0c, 8'h0f, 3'h0};
    rows[7]  = '{14'h05c0, 7'h40, 8'h55, 8'haa, 3'h1, 8'h55, 8'h00, 3'h5};
    rows[8]  = '{14'h138a, 7'h0a, 8'h77, 8'hff, 3'h5, 8'h77, 8'h7f, 3'h5};
    rows[9]  = '{14'h1000, 7'h00, 8'h77, 8'h01, 3'h2, 8'h77, 8'h00, 3'h2};
    rows[10] = '{14'h15ff, 7'h7f, 8'h77, 8'h00, 3'h0, 8'h77, 8'h08, 3'h0};
    rows[11] = '{14'h1781, 7'h01, 8'h77, 8'h7f, 3'h7, 8'h77, 8'hff, 3'h7};
    // Skip rows: skip expected, file value, instruction
    skipRows = '{{9'h0, 1'b1, 8'hfe, 14'h1809},
                 {9'h0, 1'b0, 8'h80, 14'h1b89},
                 {9'h0, 1'b1, 8'h10, 14'h1e09},
                 {9'h0, 1'b0, 8'hfb, 14'h1d09}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      wr(OFF_ACC, {24'h0, rows[i].accIn});
      wr(OFF_STATUS, {29'h0, rows[i].stIn});
      wr(fileAdr(rows[i].fIdx), {24'h0, rows[i].fIn});
      exec(rows[i].instr);
      rdChk("acc", OFF_ACC, {24'h0, rows[i].accExp});
      rdChk("file", fileAdr(rows[i].fIdx), {24'h0, rows[i].fExp});
      rdChk("status", OFF_STATUS, {29'h0, rows[i].stExp});
    end
    // Reset values after a run, then the refusals
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdChk("acc after reset", OFF_ACC, 32'h0);
    rdChk("status after reset", OFF_STATUS, 32'h0);
    rdChk("cycles after reset", OFF_CYCLES, 32'h0);
    rdChk("last file after reset", OFF_FILE_END, 32'h0);
    axiRead(12'h010, d, r);
    check("unmapped read data", d, 32'h0);
    check("unmapped read resp", {30'h0, r}, {30'h0, RESP_DECERR});
    axiWrite(12'h100, 32'hff, 4'hf, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, RESP_DECERR});
    axiWrite(OFF_ACC, 32'h5a, 4'he, r);
    check("lane off resp", {30'h0, r}, {30'h0, RESP_OKAY});
    rdChk("acc lane zero off", OFF_ACC, 32'h0);
    // Skip tests followed by an add of one that may be discarded
    foreach (skipRows[i]) begin
      skip = skipRows[i][22];
      wr(OFF_ACC, 32'h10);
      wr(OFF_STATUS, 32'h5);
      wr(fileAdr(7'h09), {24'h0, skipRows[i][21:14]});
      axiRead(OFF_CYCLES, c0, r);
      exec(skipRows[i][13:0]);
      rdChk("tested file", fileAdr(7'h09),
            {24'h0, skipRows[i][21:14]});
      rdChk("acc after test", OFF_ACC, 32'h10);
      rdChk("pending", OFF_STATUS, {28'h0, skip, 3'h5});
      exec(14'h3e01);
      rdChk("acc after next", OFF_ACC, skip ? 32'h10 : 32'h11);
      rdChk("flags after next", OFF_STATUS, skip ? 32'h5 : 32'h0);
      rdChk("cycles", OFF_CYCLES, c0 + 32'h2);
    end
    // A word outside the decoded set marks the sticky unknown bit and still counts a cycle
    exec(14'h2000);
    rdChk("unknown opcode", OFF_STATUS, 32'h10);
    rdChk("acc after unknown", OFF_ACC, 32'h11);
    rdChk("instr readback", OFF_INSTR, 32'h2000);
    test_done();
  end
endmodule
